// ==== common/dtc_pkg.sv ====
// Constants and types for the deviation and after-transmit control block
package dtc_pkg;
    // Register offsets on the control port
    localparam logic [5:0] ADDR_DEVIATION = 6'h15;
    localparam logic [5:0] ADDR_SM_ONE    = 6'h17;
    localparam logic [5:0] ADDR_SM_ZERO   = 6'h18;

    // Writable bit masks; unused bits read as zero
    localparam logic [7:0] MASK_DEVIATION = 8'h77;
    localparam logic [7:0] MASK_SM_ONE    = 8'h3f;
    localparam logic [7:0] MASK_SM_ZERO   = 8'h3f;

    // Reset values
    localparam logic [7:0] RST_DEVIATION  = 8'h47;
    localparam logic [7:0] RST_SM_ONE     = 8'h30;
    localparam logic [7:0] RST_SM_ZERO    = 8'h04;

    // Field positions
    localparam int DEV_M_LSB   = 0;
    localparam int DEV_E_LSB   = 4;
    localparam int TXOFF_LSB   = 0;
    localparam int AUTOCAL_LSB = 4;

    // After-transmit next state codes
    localparam logic [1:0] TXOFF_IDLE     = 2'h0;
    localparam logic [1:0] TXOFF_FSTX     = 2'h1;
    localparam logic [1:0] TXOFF_STAY     = 2'h2;

    // Automatic calibration policy codes
    localparam logic [1:0] AUTOCAL_NEVER  = 2'h0;
    localparam logic [1:0] AUTOCAL_LEAVE  = 2'h1;
    localparam logic [1:0] AUTOCAL_RETURN = 2'h2;
    localparam logic [1:0] AUTOCAL_FOURTH = 2'h3;

    // Modulation code for on-off keying
    localparam logic [2:0] MOD_OOK        = 3'h3;

    // Last value of the modulo-four return counter
    localparam logic [1:0] RETURN_LAST    = 2'h3;

    // Width of the signed deviation word, units of f_xosc / 2^17
    localparam int DEV_W = 12;

    // Radio control states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CAL,
        ST_SYNTH_ON_TX_READY_STATE,
        ST_TX
    } dtc_state_t;

    // Deviation magnitude: (8 + mantissa) shifted by exponent
    function automatic logic [DEV_W-1:0] dev_mag(input logic [2:0] m,
                                                 input logic [2:0] e);
        logic [DEV_W-1:0] base;
        base = {{(DEV_W-4){1'h0}}, 1'h1, m};
        return base << e;
    endfunction : dev_mag
endpackage : dtc_pkg

// ==== common/dtc_cal_if.sv ====
// Signals between the control core and the calibration policy unit
`timescale 1ns/1ns
`default_nettype none
interface dtc_cal_if;
    logic [1:0] autocal;
    logic       leave_idle;
    logic       auto_return;
    logic       cal_now;

    modport core   (output autocal, output leave_idle, output auto_return,
                    input cal_now);
    modport policy (input autocal, input leave_idle, input auto_return,
                    output cal_now);
endinterface : dtc_cal_if
`default_nettype wire

// ==== core/dtc_cal_policy.sv ====
// Automatic synthesizer calibration decision with modulo-four return count
`timescale 1ns/1ns
`default_nettype none
module dtc_cal_policy (
    // Clock and reset
    input  wire logic  clock,
    input  wire logic  nrst,
    // Core side
    dtc_cal_if.policy  cal
);
    typedef struct packed {
        logic [1:0] returns;
    } dtc_pol_t;

    dtc_pol_t r;
    dtc_pol_t next_r;

    // Count automatic returns only while the every-fourth policy is chosen
    always_comb begin
        next_r = r;
        if (cal.autocal == dtc_pkg::AUTOCAL_FOURTH && cal.auto_return) begin
            next_r.returns = r.returns + 2'h1; // R9
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // Decision is combinational so the core can divert in the same cycle
    always_comb begin
        case (cal.autocal)
            dtc_pkg::AUTOCAL_LEAVE:  cal.cal_now = cal.leave_idle; // R7
            dtc_pkg::AUTOCAL_RETURN: cal.cal_now = cal.auto_return; // R8
            dtc_pkg::AUTOCAL_FOURTH: cal.cal_now = cal.auto_return &&
                                     r.returns == dtc_pkg::RETURN_LAST; // R9
            default:                 cal.cal_now = 1'h0; // R6
        endcase
    end

    a_fourth_count: assert property (@(posedge clock) disable iff (!nrst) // R9
        (cal.autocal == dtc_pkg::AUTOCAL_FOURTH && cal.auto_return
         && !cal.cal_now) |=> r.returns == $past(r.returns) + 2'h1)
        else $error("return counter did not advance");
    a_fourth_wrap: assert property (@(posedge clock) disable iff (!nrst) // R9
        (cal.autocal == dtc_pkg::AUTOCAL_FOURTH && cal.cal_now)
        |=> r.returns == 2'h0)
        else $error("calibration not on fourth return");
endmodule : dtc_cal_policy
`default_nettype wire

// ==== core/dtc_control.sv ====
// Deviation setting, after-transmit state choice and calibration control
//
// Function
// R1 - FSK zero symbol uses negative deviation, one symbol positive deviation.
// R2 - Deviation magnitude is (8 + mantissa) times two to the exponent.
// R3 - Under on-off keying the deviation fields are ignored.
// R4 - After a packet: code 00 goes idle, 01 goes synth-on ready.
// R5 - Code 10 stays in transmit and restarts the preamble at once.
// R6 - Autocal 00 never calibrates alone; host uses the calibrate strobe.
// R7 - Autocal 01 calibrates when leaving idle for transmit or ready.
// R8 - Autocal 10 calibrates on each automatic return from transmit to idle.
// R9 - Autocal 11 calibrates on every fourth automatic return to idle.
// R10 - Host avoids reserved after-transmit code and writes unused bits zero.
`timescale 1ns/1ns
`default_nettype none
module dtc_control #(
    parameter int CAL_CYCLES = 16
) (
    // Clock and reset
    input  wire logic                      clock,
    input  wire logic                      nrst,
    // Register port
    input  wire logic [5:0]                reg_addr,
    input  wire logic [7:0]                reg_wdata,
    input  wire logic                      reg_write,
    input  wire logic                      reg_read,
    output logic [7:0]                     reg_rdata,
    // Command strobes
    input  wire logic                      tx_strobe,
    input  wire logic                      synth_on_tx_ready_state_strobe,
    input  wire logic                      idle_strobe,
    input  wire logic                      calibrate_strobe,
    // Modem side
    input  wire logic [2:0]                mod_format,
    input  wire logic                      tx_symbol,
    input  wire logic                      packet_done,
    output logic signed [dtc_pkg::DEV_W-1:0] dev_offset,
    output logic                           preamble_restart,
    // State
    output dtc_pkg::dtc_state_t            radio_state,
    output logic                           cal_busy
);
    localparam int CW = $clog2(CAL_CYCLES + 1);
    // Longest calibration the leave-idle check can still watch to its end
    localparam int CAL_MAX = 300;

    if (CAL_CYCLES < 1 || CAL_CYCLES > CAL_MAX) begin : g_bad_cal
        $error("CAL_CYCLES must lie between one and CAL_MAX");
    end

    typedef struct packed {
        logic [7:0]                 deviation;
        logic [7:0]                 sm_one;
        logic [7:0]                 sm_zero;
        logic [7:0]                 rdata;
        dtc_pkg::dtc_state_t        state;
        dtc_pkg::dtc_state_t        ret_state;
        logic [CW-1:0]              cal_left;
        logic [dtc_pkg::DEV_W-1:0]  offset;
        logic                       restart;
    } dtc_core_t;

    dtc_core_t r;
    dtc_core_t next_r;
    dtc_cal_if cal_bus ();

    logic [2:0]                dev_m;
    logic [2:0]                dev_e;
    logic [1:0]                txoff;
    logic [1:0]                autocal;
    logic                      is_ook;
    logic [dtc_pkg::DEV_W-1:0] mag;

    // Field views of the stored registers
    assign dev_m   = r.deviation[dtc_pkg::DEV_M_LSB +: 3];
    assign dev_e   = r.deviation[dtc_pkg::DEV_E_LSB +: 3];
    assign txoff   = r.sm_one[dtc_pkg::TXOFF_LSB +: 2];
    assign autocal = r.sm_zero[dtc_pkg::AUTOCAL_LSB +: 2];
    assign is_ook  = mod_format == dtc_pkg::MOD_OOK;
    assign mag     = dtc_pkg::dev_mag(dev_m, dev_e); // R2

    // Events seen by the calibration policy; strobe priority applied here
    assign cal_bus.autocal     = autocal;
    assign cal_bus.leave_idle  = r.state == dtc_pkg::ST_IDLE &&
                                 !calibrate_strobe &&
                                 (tx_strobe || synth_on_tx_ready_state_strobe); // R7
    // Reserved code 11 is handled like 00 so a bad write cannot hang TX
    assign cal_bus.auto_return = r.state == dtc_pkg::ST_TX && !idle_strobe &&
                                 packet_done &&
                                 txoff != dtc_pkg::TXOFF_FSTX &&
                                 txoff != dtc_pkg::TXOFF_STAY; // R8

    dtc_cal_policy u_policy (
        .clock (clock),
        .nrst  (nrst),
        .cal   (cal_bus.policy)
    );

    // Register file, deviation word and radio control state machine
    always_comb begin
        dtc_pkg::dtc_state_t target;
        next_r = r;
        target = dtc_pkg::ST_TX;
        next_r.restart = 1'h0;

        if (reg_write) begin
            if (reg_addr == dtc_pkg::ADDR_DEVIATION) begin
                next_r.deviation = reg_wdata & dtc_pkg::MASK_DEVIATION;
            end else if (reg_addr == dtc_pkg::ADDR_SM_ONE) begin
                next_r.sm_one = reg_wdata & dtc_pkg::MASK_SM_ONE;
            end else if (reg_addr == dtc_pkg::ADDR_SM_ZERO) begin
                next_r.sm_zero = reg_wdata & dtc_pkg::MASK_SM_ZERO;
            end
        end

        // Read data held until the next read; unmapped offsets read zero
        if (reg_read) begin
            if (reg_addr == dtc_pkg::ADDR_DEVIATION) begin
                next_r.rdata = r.deviation;
            end else if (reg_addr == dtc_pkg::ADDR_SM_ONE) begin
                next_r.rdata = r.sm_one;
            end else if (reg_addr == dtc_pkg::ADDR_SM_ZERO) begin
                next_r.rdata = r.sm_zero;
            end else begin
                next_r.rdata = 8'h00;
            end
        end

        // Signed offset from carrier; zero under on-off keying
        if (is_ook) begin
            next_r.offset = '0; // R3
        end else if (tx_symbol) begin
            next_r.offset = mag; // R1
        end else begin
            next_r.offset = -mag; // R1
        end

        case (r.state)
            dtc_pkg::ST_IDLE: begin
                if (calibrate_strobe) begin
                    next_r.state     = dtc_pkg::ST_CAL; // R6
                    next_r.ret_state = dtc_pkg::ST_IDLE;
                    next_r.cal_left  = CW'(CAL_CYCLES - 1);
                end else if (tx_strobe || synth_on_tx_ready_state_strobe) begin
                    target = tx_strobe ? dtc_pkg::ST_TX : dtc_pkg::ST_SYNTH_ON_TX_READY_STATE;
                    if (cal_bus.cal_now) begin
                        next_r.state     = dtc_pkg::ST_CAL; // R7
                        next_r.ret_state = target;
                        next_r.cal_left  = CW'(CAL_CYCLES - 1);
                    end else begin
                        next_r.state = target;
                    end
                end
            end
            dtc_pkg::ST_CAL: begin
                if (r.cal_left == '0) begin
                    next_r.state = r.ret_state;
                end else begin
                    next_r.cal_left = r.cal_left - CW'(1);
                end
            end
            dtc_pkg::ST_SYNTH_ON_TX_READY_STATE: begin
                if (idle_strobe) begin
                    next_r.state = dtc_pkg::ST_IDLE;
                end else if (tx_strobe) begin
                    next_r.state = dtc_pkg::ST_TX;
                end
            end
            default: begin
                if (idle_strobe) begin
                    next_r.state = dtc_pkg::ST_IDLE;
                end else if (packet_done) begin
                    case (txoff)
                        dtc_pkg::TXOFF_FSTX: begin
                            next_r.state = dtc_pkg::ST_SYNTH_ON_TX_READY_STATE; // R4
                        end
                        dtc_pkg::TXOFF_STAY: begin
                            next_r.restart = 1'h1; // R5
                        end
                        default: begin
                            if (cal_bus.cal_now) begin
                                next_r.state     = dtc_pkg::ST_CAL; // R8
                                next_r.ret_state = dtc_pkg::ST_IDLE;
                                next_r.cal_left  = CW'(CAL_CYCLES - 1);
                            end else begin
                                next_r.state = dtc_pkg::ST_IDLE; // R4
                            end
                        end
                    endcase
                end
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            r           <= '0;
            r.deviation <= dtc_pkg::RST_DEVIATION;
            r.sm_one    <= dtc_pkg::RST_SM_ONE;
            r.sm_zero   <= dtc_pkg::RST_SM_ZERO;
            r.state     <= dtc_pkg::ST_IDLE;
            r.ret_state <= dtc_pkg::ST_IDLE;
        end else begin
            r <= next_r;
        end
    end

    // Outputs straight from the state register
    assign reg_rdata        = r.rdata;
    assign dev_offset       = r.offset;
    assign preamble_restart = r.restart;
    assign radio_state      = r.state;
    assign cal_busy         = r.state == dtc_pkg::ST_CAL;

    a_ook_no_dev: assert property (@(posedge clock) disable iff (!nrst) // R3
        is_ook |=> dev_offset == '0)
        else $error("deviation applied under on-off keying");
    a_zero_neg: assert property (@(posedge clock) disable iff (!nrst) // R1
        (!is_ook && !tx_symbol) |=> dev_offset < 0)
        else $error("zero symbol not at negative deviation");
    a_dev_scale: assert property (@(posedge clock) disable iff (!nrst) // R2
        (!is_ook && tx_symbol) |=>
        dev_offset == $signed(dtc_pkg::dev_mag($past(dev_m), $past(dev_e))))
        else $error("deviation magnitude wrong");
    a_txoff_fstx: assert property (@(posedge clock) disable iff (!nrst) // R4
        (r.state == dtc_pkg::ST_TX && packet_done && !idle_strobe &&
         txoff == dtc_pkg::TXOFF_FSTX) |=> radio_state == dtc_pkg::ST_SYNTH_ON_TX_READY_STATE)
        else $error("no synth-on ready after packet");
    a_txoff_idle: assert property (@(posedge clock) disable iff (!nrst) // R4
        (r.state == dtc_pkg::ST_TX && packet_done && !idle_strobe &&
         txoff == dtc_pkg::TXOFF_IDLE && autocal == dtc_pkg::AUTOCAL_NEVER)
        |=> radio_state == dtc_pkg::ST_IDLE)
        else $error("no idle after packet");
    a_txoff_stay: assert property (@(posedge clock) disable iff (!nrst) // R5
        (r.state == dtc_pkg::ST_TX && packet_done && !idle_strobe &&
         txoff == dtc_pkg::TXOFF_STAY)
        |=> radio_state == dtc_pkg::ST_TX && preamble_restart)
        else $error("preamble not restarted in transmit");
    a_never_cal: assert property (@(posedge clock) disable iff (!nrst) // R6
        (autocal == dtc_pkg::AUTOCAL_NEVER && !cal_busy && !calibrate_strobe)
        |=> !cal_busy)
        else $error("calibration started without strobe");
    a_cal_leave: assert property (@(posedge clock) disable iff (!nrst) // R7
        (cal_bus.leave_idle && autocal == dtc_pkg::AUTOCAL_LEAVE)
        |=> cal_busy ##[1:CAL_MAX] radio_state != dtc_pkg::ST_CAL)
        else $error("no calibration on leaving idle");
    a_cal_return: assert property (@(posedge clock) disable iff (!nrst) // R8
        (cal_bus.auto_return && autocal == dtc_pkg::AUTOCAL_RETURN)
        |=> cal_busy && r.ret_state == dtc_pkg::ST_IDLE)
        else $error("no calibration on return to idle");
endmodule : dtc_control
`default_nettype wire

// ==== verification/deviation_and_txoff_control_regs_tb.sv ====
// Self-checking bench for the deviation and after-transmit control block
`timescale 1ns/1ns
`default_nettype none
module deviation_and_txoff_control_regs_tb;
    // Short calibration keeps the run brief
    localparam int CAL_N = 2;
    localparam logic [4:0] C_TX   = 5'h10;
    localparam logic [4:0] C_FS   = 5'h08;
    localparam logic [4:0] C_IDLE = 5'h04;
    localparam logic [4:0] C_CAL  = 5'h02;
    localparam logic [4:0] C_PKT  = 5'h01;

    logic                            clock;
    logic                            nrst;
    logic [5:0]                      reg_addr;
    logic [7:0]                      reg_wdata;
    logic                            reg_write;
    logic                            reg_read;
    logic [7:0]                      reg_rdata;
    logic [4:0]                      cmd;
    logic [2:0]                      mod_format;
    logic                            tx_symbol;
    logic signed [dtc_pkg::DEV_W-1:0] dev_offset;
    logic                            preamble_restart;
    dtc_pkg::dtc_state_t             radio_state;
    logic                            cal_busy;
    int                              num_errors;
    int                              num_checks;

    dtc_control #(.CAL_CYCLES(CAL_N)) i_dtc_control (
        .clock            (clock),
        .nrst             (nrst),
        .reg_addr         (reg_addr),
        .reg_wdata        (reg_wdata),
        .reg_write        (reg_write),
        .reg_read         (reg_read),
        .reg_rdata        (reg_rdata),
        .tx_strobe        (cmd[4]),
        .synth_on_tx_ready_state_strobe    (cmd[3]),
        .idle_strobe      (cmd[2]),
        .calibrate_strobe (cmd[1]),
        .mod_format       (mod_format),
        .tx_symbol        (tx_symbol),
        .packet_done      (cmd[0]),
        .dev_offset       (dev_offset),
        .preamble_restart (preamble_restart),
        .radio_state      (radio_state),
        .cal_busy         (cal_busy)
    );

    // Free-running 50 MHz clock
    initial begin
        clock = 1'h0;
        forever #10 clock = ~clock;
    end

    task automatic check(input string name, input logic [11:0] seen,
                         input logic [11:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic give_verdict();
        $display("Checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : give_verdict

    // Register port cycles, one strobe cycle each
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge clock);
        reg_addr  = a;
        reg_wdata = d;
        reg_write = 1'h1;
        @(negedge clock);
        reg_write = 1'h0;
    endtask : wr

    task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
        @(negedge clock);
        reg_addr = a;
        reg_read = 1'h1;
        @(negedge clock);
        reg_read = 1'h0;
        check("reg_rdata", {4'h0, reg_rdata}, {4'h0, exp});
    endtask : rd_chk

    // One-cycle command pulse; state is judged one edge later
    task automatic pulse(input logic [4:0] v);
        @(negedge clock);
        cmd = v;
        @(negedge clock);
        cmd = 5'h00;
    endtask : pulse

    task automatic st_chk(input dtc_pkg::dtc_state_t exp);
        check("radio_state", {10'h000, radio_state}, {10'h000, exp});
    endtask : st_chk

    // Calibration must last exactly CAL_N cycles before the return state
    task automatic cal_then(input dtc_pkg::dtc_state_t ret);
        st_chk(dtc_pkg::ST_CAL);
        check("cal_busy", {11'h000, cal_busy}, 12'h001);
        repeat (CAL_N - 1) @(negedge clock);
        st_chk(dtc_pkg::ST_CAL);
        @(negedge clock);
        st_chk(ret);
    endtask : cal_then

    task automatic cfg(input logic [1:0] autocal, input logic [1:0] txoff);
        wr(dtc_pkg::ADDR_SM_ONE, {6'h0c, txoff});
        wr(dtc_pkg::ADDR_SM_ZERO, {2'h0, autocal, 4'h4});
    endtask : cfg

    task automatic test_regs();
        rd_chk(dtc_pkg::ADDR_DEVIATION, 8'h47);
        rd_chk(dtc_pkg::ADDR_SM_ONE, 8'h30);
        rd_chk(dtc_pkg::ADDR_SM_ZERO, 8'h04);
        rd_chk(6'h16, 8'h00);
        // Every writable bit set; unused bits and the reserved code kept clear
        wr(dtc_pkg::ADDR_DEVIATION, 8'h77);
        wr(dtc_pkg::ADDR_SM_ONE, 8'h3e);
        wr(dtc_pkg::ADDR_SM_ZERO, 8'h3f);
        rd_chk(dtc_pkg::ADDR_DEVIATION, 8'h77);
        rd_chk(dtc_pkg::ADDR_SM_ONE, 8'h3e);
        rd_chk(dtc_pkg::ADDR_SM_ZERO, 8'h3f);
        cfg(2'h0, 2'h0);
        $display("test_regs done");
    endtask : test_regs

    task automatic dev_chk(input logic [2:0] mf, input logic sym,
                           input int exp);
        @(negedge clock);
        mod_format = mf;
        tx_symbol  = sym;
        @(negedge clock);
        check("dev_offset", dev_offset, 12'(exp));
    endtask : dev_chk

    task automatic test_deviation();
        wr(dtc_pkg::ADDR_DEVIATION, 8'h23);
        dev_chk(3'h0, 1'h1, 44);
        dev_chk(3'h0, 1'h0, -44);
        wr(dtc_pkg::ADDR_DEVIATION, 8'h77);
        dev_chk(3'h4, 1'h1, 1920);
        dev_chk(3'h1, 1'h0, -1920);
        dev_chk(3'h3, 1'h1, 0);
        dev_chk(3'h3, 1'h0, 0);
        $display("test_deviation done");
    endtask : test_deviation

    task automatic test_txoff();
        pulse(C_TX);
        st_chk(dtc_pkg::ST_TX);
        pulse(C_PKT);
        st_chk(dtc_pkg::ST_IDLE);
        cfg(2'h0, 2'h1);
        pulse(C_TX);
        pulse(C_PKT);
        st_chk(dtc_pkg::ST_SYNTH_ON_TX_READY_STATE);
        pulse(C_TX);
        cfg(2'h0, 2'h2);
        pulse(C_PKT);
        check("restart", {11'h000, preamble_restart}, 12'h001);
        st_chk(dtc_pkg::ST_TX);
        @(negedge clock);
        check("restart", {11'h000, preamble_restart}, 12'h000);
        pulse(C_IDLE);
        pulse(C_CAL);
        cal_then(dtc_pkg::ST_IDLE);
        $display("test_txoff done");
    endtask : test_txoff

    task automatic test_autocal();
        int i;
        cfg(2'h1, 2'h0);
        pulse(C_TX);
        cal_then(dtc_pkg::ST_TX);
        pulse(C_IDLE);
        pulse(C_FS);
        cal_then(dtc_pkg::ST_SYNTH_ON_TX_READY_STATE);
        pulse(C_IDLE);
        cfg(2'h2, 2'h0);
        pulse(C_TX);
        st_chk(dtc_pkg::ST_TX);
        pulse(C_PKT);
        cal_then(dtc_pkg::ST_IDLE);
        pulse(C_TX);
        pulse(C_IDLE);
        st_chk(dtc_pkg::ST_IDLE);
        cfg(2'h3, 2'h0);
        for (i = 1; i <= 4; i++) begin
            pulse(C_TX);
            pulse(C_PKT);
            if (i == 4)
                cal_then(dtc_pkg::ST_IDLE);
            else
                st_chk(dtc_pkg::ST_IDLE);
        end
        $display("test_autocal done");
    endtask : test_autocal

    // Cuts a hang short well beyond the expected run length
    initial begin
        repeat (5000) @(posedge clock);
        num_errors++;
        give_verdict();
    end

    // Main sequence: reset for 20 cycles, then the scenarios
    initial begin
        num_errors = 0;
        num_checks = 0;
        nrst       = 1'h0;
        reg_addr   = 6'h00;
        reg_wdata  = 8'h00;
        reg_write  = 1'h0;
        reg_read   = 1'h0;
        cmd        = 5'h00;
        mod_format = 3'h0;
        tx_symbol  = 1'h0;
        repeat (20) @(negedge clock);
        nrst = 1'h1;
        test_regs();
        test_deviation();
        test_txoff();
        test_autocal();
        give_verdict();
    end
endmodule : deviation_and_txoff_control_regs_tb
`default_nettype wire
